// File: lrc_top.sv
// Purpose: control of four linear regulators: enables, mode and voltage codes
// Assumes: standby_state and seq_enable_set come from logic on mclk
// Notes:   outputs are registered, one cycle behind the control state
`timescale 1ns/1ps
`default_nettype none

module lrc_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [lrc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lrc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lrc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic standby_state,
  input wire logic [lrc_pkg::NUM_REG-1:0] seq_enable_set,
  input wire logic [lrc_pkg::NUM_REG-1:0] otp_pass_through_select,
  input wire logic [lrc_pkg::NUM_REG*lrc_pkg::CODE_W-1:0] otp_default_voltage_code,
  input wire logic second_reg_enable_pin,
  input wire logic voltage_select_pin,
  output logic [lrc_pkg::NUM_REG-1:0] regulating_on,
  output logic [lrc_pkg::NUM_REG-1:0] pass_switch_closed,
  output logic [lrc_pkg::NUM_REG-1:0] pulldown_on,
  output logic [lrc_pkg::NUM_REG*lrc_pkg::CODE_W-1:0] vout_code,
  output logic [lrc_pkg::NUM_REG*lrc_pkg::MV_W-1:0] vout_mv
);
  import lrc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lrc_state_t state_r, state_nxt;
  logic [NUM_REG-1:0] reg_run_state_enable_r, reg_run_state_enable_nxt;
  logic [NUM_REG-1:0] reg_standby_state_enable_r, reg_standby_state_enable_nxt;
  logic [NUM_REG-1:0] pass_switch_enable_r, pass_switch_enable_nxt;
  logic [NUM_REG-1:0] ls_sel_r, ls_sel_nxt;
  logic [CODE_W-1:0] run_voltage_code_r [NUM_REG];
  logic [CODE_W-1:0] run_voltage_code_nxt [NUM_REG];
  logic [CODE_W-1:0] standby_voltage_code_r [NUM_REG];
  logic [CODE_W-1:0] standby_voltage_code_nxt [NUM_REG];
  logic hw_ctl_r, hw_ctl_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [NUM_REG-1:0] reg_on_r, reg_on_nxt;
  logic [NUM_REG-1:0] sw_on_r, sw_on_nxt;
  logic [NUM_REG-1:0] pd_r, pd_nxt;
  logic [NUM_REG*CODE_W-1:0] code_r, code_nxt;
  logic [NUM_REG*MV_W-1:0] mv_r, mv_nxt;

  logic [1:0] pins_sync;
  logic [NUM_REG-1:0] eff_en;
  logic [CODE_W-1:0] eff_code [NUM_REG];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  lrc_pin_sync #(
    .W(2)
  ) u_pin_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin_in({voltage_select_pin, second_reg_enable_pin}),
    .pin_sync(pins_sync)
  );

  // ----------------------------------------------------------------
  // Effective enable and code for the present state
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_REG; i++) begin
      if (standby_state) begin
        eff_en[i] = reg_standby_state_enable_r[i];
        eff_code[i] = standby_voltage_code_r[i];
      end else begin
        eff_en[i] = reg_run_state_enable_r[i];
        eff_code[i] = run_voltage_code_r[i];
      end
    end
    // Pin control of the second regulator overrides the register path
    if (hw_ctl_r) begin
      eff_en[HW_REG_IDX] = pins_sync[0];
      eff_code[HW_REG_IDX] = pins_sync[1] ? standby_voltage_code_r[HW_REG_IDX]
                                          : run_voltage_code_r[HW_REG_IDX];
    end
  end

  // ----------------------------------------------------------------
  // Control registers and register port
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    reg_run_state_enable_nxt = reg_run_state_enable_r;
    reg_standby_state_enable_nxt = reg_standby_state_enable_r;
    pass_switch_enable_nxt = pass_switch_enable_r;
    ls_sel_nxt = ls_sel_r;
    hw_ctl_nxt = hw_ctl_r;
    rdata_nxt = '0;
    for (int i = 0; i < NUM_REG; i++) begin
      run_voltage_code_nxt[i] = run_voltage_code_r[i];
      standby_voltage_code_nxt[i] = standby_voltage_code_r[i];
    end
    case (state_r)
      LRC_ST_LOAD: begin
        // One cycle after reset release: take the programmed defaults
        for (int i = 0; i < NUM_REG; i++) begin
          run_voltage_code_nxt[i] = otp_default_voltage_code[i*CODE_W +: CODE_W];
          standby_voltage_code_nxt[i] = otp_default_voltage_code[i*CODE_W +: CODE_W];
        end
        ls_sel_nxt = otp_pass_through_select;
        state_nxt = LRC_ST_ACTIVE;
      end
      LRC_ST_ACTIVE: begin
        if (reg_wr) begin
          for (int i = 0; i < NUM_REG; i++) begin
            if (reg_addr == OFS_CTRL_BASE + 8'(4 * i)) begin
              reg_run_state_enable_nxt[i] = reg_wdata[CTRL_RUN_EN_BIT];
              reg_standby_state_enable_nxt[i] = reg_wdata[CTRL_STBY_EN_BIT];
              pass_switch_enable_nxt[i] = reg_wdata[CTRL_SW_EN_BIT];
            end
            if (reg_addr == OFS_VOLT_BASE + 8'(4 * i)) begin
              run_voltage_code_nxt[i] = reg_wdata[VOLT_RUN_LSB +: CODE_W];
              standby_voltage_code_nxt[i] = reg_wdata[VOLT_STBY_LSB +: CODE_W];
            end
          end
          if (reg_addr == OFS_HWCTL) begin
            hw_ctl_nxt = reg_wdata[HWCTL_EN_BIT];
          end
        end
        // Sequencer set wins over a software clear in the same cycle
        reg_run_state_enable_nxt = reg_run_state_enable_nxt | seq_enable_set;
        reg_standby_state_enable_nxt = reg_standby_state_enable_nxt | seq_enable_set;
        if (reg_rd) begin
          for (int i = 0; i < NUM_REG; i++) begin
            if (reg_addr == OFS_CTRL_BASE + 8'(4 * i)) begin
              rdata_nxt[CTRL_RUN_EN_BIT] = reg_run_state_enable_r[i];
              rdata_nxt[CTRL_STBY_EN_BIT] = reg_standby_state_enable_r[i];
              rdata_nxt[CTRL_SW_EN_BIT] = pass_switch_enable_r[i];
              rdata_nxt[CTRL_LS_BIT] = ls_sel_r[i];
            end
            if (reg_addr == OFS_VOLT_BASE + 8'(4 * i)) begin
              rdata_nxt[VOLT_RUN_LSB +: CODE_W] = run_voltage_code_r[i];
              rdata_nxt[VOLT_STBY_LSB +: CODE_W] = standby_voltage_code_r[i];
            end
          end
          if (reg_addr == OFS_STATUS) begin
            for (int i = 0; i < NUM_REG; i++) begin
              rdata_nxt[i*STAT_STRIDE + STAT_REGULATING_BIT] = reg_on_r[i];
              rdata_nxt[i*STAT_STRIDE + STAT_SWITCH_BIT] = sw_on_r[i];
              rdata_nxt[i*STAT_STRIDE + STAT_PULLDOWN_BIT] = pd_r[i];
            end
            rdata_nxt[STAT_STANDBY_BIT] = standby_state;
          end
          if (reg_addr == OFS_HWCTL) begin
            rdata_nxt[HWCTL_EN_BIT] = hw_ctl_r;
          end
        end
      end
      default: begin
        state_nxt = LRC_ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= LRC_ST_LOAD;
      reg_run_state_enable_r <= RST_ENABLES;
      reg_standby_state_enable_r <= RST_ENABLES;
      pass_switch_enable_r <= RST_ENABLES;
      ls_sel_r <= RST_ENABLES;
      hw_ctl_r <= RST_HWCTL;
      rdata_r <= '0;
      for (int i = 0; i < NUM_REG; i++) begin
        run_voltage_code_r[i] <= RST_CODE;
        standby_voltage_code_r[i] <= RST_CODE;
      end
    end else begin
      state_r <= state_nxt;
      reg_run_state_enable_r <= reg_run_state_enable_nxt;
      reg_standby_state_enable_r <= reg_standby_state_enable_nxt;
      pass_switch_enable_r <= pass_switch_enable_nxt;
      ls_sel_r <= ls_sel_nxt;
      hw_ctl_r <= hw_ctl_nxt;
      rdata_r <= rdata_nxt;
      for (int i = 0; i < NUM_REG; i++) begin
        run_voltage_code_r[i] <= run_voltage_code_nxt[i];
        standby_voltage_code_r[i] <= standby_voltage_code_nxt[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Regulator drive
  // ----------------------------------------------------------------
  always_comb begin
    reg_on_nxt = '0;
    sw_on_nxt = '0;
    pd_nxt = {NUM_REG{1'b1}};
    code_nxt = '0;
    mv_nxt = '0;
    for (int i = 0; i < NUM_REG; i++) begin
      code_nxt[i*CODE_W +: CODE_W] = eff_code[i];
      mv_nxt[i*MV_W +: MV_W] = lrc_code_to_mv(eff_code[i]);
      // Held off with pull-down until the defaults are loaded
      if (state_r == LRC_ST_ACTIVE && eff_en[i]) begin
        pd_nxt[i] = 1'b0;
        if (ls_sel_r[i]) begin
          sw_on_nxt[i] = pass_switch_enable_r[i];
        end else begin
          reg_on_nxt[i] = 1'b1;
        end
      end // else off with pull-down, mode bit ignored
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_on_r <= '0;
      sw_on_r <= '0;
      pd_r <= {NUM_REG{1'b1}};
      code_r <= '0;
      mv_r <= '0;
    end else begin
      reg_on_r <= reg_on_nxt;
      sw_on_r <= sw_on_nxt;
      pd_r <= pd_nxt;
      code_r <= code_nxt;
      mv_r <= mv_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign regulating_on = reg_on_r;
  assign pass_switch_closed = sw_on_r;
  assign pulldown_on = pd_r;
  assign vout_code = code_r;
  assign vout_mv = mv_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  for (genvar g = 0; g < NUM_REG; g++) begin : g_chk
    localparam bit HW = (g == HW_REG_IDX);

    AST_RUN_OFF: assert property (
      (!standby_state && !reg_run_state_enable_r[g] && !(HW && hw_ctl_r))
      |=> (!regulating_on[g] && !pass_switch_closed[g]))
      else $error("regulator on in run state with run enable low");

    AST_STBY_OFF: assert property (
      (standby_state && !reg_standby_state_enable_r[g] && !(HW && hw_ctl_r))
      |=> (!regulating_on[g] && !pass_switch_closed[g]))
      else $error("regulator on in standby with standby enable low");

    AST_PULLDOWN: assert property (
      (state_r == LRC_ST_ACTIVE && !eff_en[g]) |=> pulldown_on[g])
      else $error("pull-down not active while regulator disabled");

    AST_NORMAL_MODE: assert property (
      (state_r == LRC_ST_ACTIVE && eff_en[g] && !ls_sel_r[g])
      |=> (regulating_on[g] && !pulldown_on[g] && !pass_switch_closed[g]))
      else $error("regulator not regulating when enabled in normal mode");

    AST_SWITCH_MODE: assert property (
      (state_r == LRC_ST_ACTIVE && eff_en[g] && ls_sel_r[g])
      |=> (!regulating_on[g] && pass_switch_closed[g] == $past(pass_switch_enable_r[g])))
      else $error("load switch does not follow its enable bit");

    AST_RUN_CODE: assert property (
      (!standby_state && !(HW && hw_ctl_r))
      |=> vout_code[g*CODE_W +: CODE_W] == $past(run_voltage_code_r[g]))
      else $error("run voltage code not applied");

    AST_STBY_CODE: assert property (
      (standby_state && !(HW && hw_ctl_r))
      |=> vout_code[g*CODE_W +: CODE_W] == $past(standby_voltage_code_r[g]))
      else $error("standby voltage code not applied");

    // Reset leaves code and set point both at zero, so the load cycle is skipped
    AST_MV_DECODE: assert property (
      (state_r == LRC_ST_ACTIVE)
      |-> vout_mv[g*MV_W +: MV_W] == lrc_code_to_mv(vout_code[g*CODE_W +: CODE_W]))
      else $error("voltage code and set point disagree");
  end

  sequence s_load_done;
    state_r == LRC_ST_LOAD ##1 state_r == LRC_ST_ACTIVE;
  endsequence

  AST_OTP_LOAD: assert property (
    s_load_done |-> (run_voltage_code_r[0] == $past(otp_default_voltage_code[3:0])
      && standby_voltage_code_r[0] == $past(otp_default_voltage_code[3:0])
      && ls_sel_r == $past(otp_pass_through_select)))
    else $error("defaults not taken at power up");

  AST_LS_FIXED: assert property (
    (state_r == LRC_ST_ACTIVE) |=> $stable(ls_sel_r))
    else $error("pass-through select changed at run time");

  AST_SEQ_SET: assert property (
    (state_r == LRC_ST_ACTIVE && seq_enable_set[0])
    |=> (reg_run_state_enable_r[0] && reg_standby_state_enable_r[0]))
    else $error("sequencer did not set both enables");

  AST_PIN_CTRL: assert property (
    (hw_ctl_r && state_r == LRC_ST_ACTIVE)
    |=> pulldown_on[HW_REG_IDX] == !$past(pins_sync[0]))
    else $error("second regulator ignores its enable pin");

  AST_STATE_SWITCH: assert property (
    (state_r == LRC_ST_ACTIVE && $changed(standby_state))
    |=> pulldown_on[0] == !$past(eff_en[0]))
    else $error("state change did not apply new enable");

endmodule

`default_nettype wire

// File: lrc_pkg.sv
// Purpose: shared constants, types and decode for the linear regulator control
// Assumes: 32-bit register port, one aligned word per register
// Notes:   status and pin-control register offsets are local choices

package lrc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_REG = 4;
  localparam int CODE_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MV_W = 16;
  localparam int HW_REG_IDX = 1;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_BASE = 8'h00;
  localparam logic [7:0] OFS_VOLT_BASE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_HWCTL = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_EN_BIT = 0;
  localparam int CTRL_STBY_EN_BIT = 1;
  localparam int CTRL_SW_EN_BIT = 2;
  localparam int CTRL_LS_BIT = 3;
  localparam int VOLT_RUN_LSB = 0;
  localparam int VOLT_STBY_LSB = 4;
  localparam int STAT_STRIDE = 4;
  localparam int STAT_REGULATING_BIT = 0;
  localparam int STAT_SWITCH_BIT = 1;
  localparam int STAT_PULLDOWN_BIT = 2;
  localparam int STAT_STANDBY_BIT = 16;
  localparam int HWCTL_EN_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_ENABLES = 4'h0;
  localparam logic [3:0] RST_CODE = 4'h0;
  localparam logic RST_HWCTL = 1'b0;

  typedef enum logic {LRC_ST_LOAD, LRC_ST_ACTIVE} lrc_state_t;

  // Set point in millivolts for a 4-bit voltage code
  function automatic logic [15:0] lrc_code_to_mv(input logic [3:0] code);
    logic [15:0] mv;
    mv = 16'h0000;
    case (code)
      4'h0: mv = 16'd1500;
      4'h1: mv = 16'd1600;
      4'h2: mv = 16'd1800;
      4'h3: mv = 16'd1850;
      4'h4: mv = 16'd2150;
      4'h5: mv = 16'd2500;
      4'h6: mv = 16'd2800;
      4'h7: mv = 16'd3000;
      4'h8: mv = 16'd3100;
      4'h9: mv = 16'd3150;
      4'ha: mv = 16'd3200;
      4'hb: mv = 16'd3300;
      4'hc: mv = 16'd3350;
      4'hd: mv = 16'd1650;
      4'he: mv = 16'd1700;
      default: mv = 16'd5000;
    endcase
    return mv;
  endfunction

endpackage

// File: lrc_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to mclk
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module lrc_pin_sync #(
  parameter int W = 2
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] val_r;
  logic [W-1:0] val_nxt;

  always_comb begin
    val_nxt = val_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        val_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      val_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      val_r <= val_nxt;
    end
  end

  assign pin_sync = val_r;

endmodule

`default_nettype wire

// File: lrc_top_tb.sv
// Purpose: self-checking bench for the linear regulator control block
// Assumes: register port with read data in the cycle after the read strobe
// Notes:   OTP inputs held at fixed values; regulator 2 is the load switch one
`timescale 1ns/1ps
`default_nettype none

module lrc_top_tb;
  import lrc_pkg::*;

  // --------------------------------------------------------------
  // Stimulus and observed signals
  // --------------------------------------------------------------
  localparam logic [3:0] OTP_SEL = 4'h4;
  localparam logic [15:0] OTP_CODE = 16'h4d2a;
  localparam logic [15:0] MV_TAB [16] = '{16'd1500, 16'd1600, 16'd1800, 16'd1850,
    16'd2150, 16'd2500, 16'd2800, 16'd3000, 16'd3100, 16'd3150, 16'd3200,
    16'd3300, 16'd3350, 16'd1650, 16'd1700, 16'd5000};

  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic standby_state = 1'b0;
  logic [3:0] seq_enable_set = 4'h0;
  logic second_reg_enable_pin = 1'b0;
  logic voltage_select_pin = 1'b0;
  logic [3:0] regulating_on;
  logic [3:0] pass_switch_closed;
  logic [3:0] pulldown_on;
  logic [15:0] vout_code;
  logic [63:0] vout_mv;
  int n_fail = 0;
  int comparisons = 0;

  always #2.5 mclk = ~mclk;

  lrc_top dut (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .standby_state(standby_state), .seq_enable_set(seq_enable_set),
    .otp_pass_through_select(OTP_SEL), .otp_default_voltage_code(OTP_CODE),
    .second_reg_enable_pin(second_reg_enable_pin),
    .voltage_select_pin(voltage_select_pin), .regulating_on(regulating_on),
    .pass_switch_closed(pass_switch_closed), .pulldown_on(pulldown_on),
    .vout_code(vout_code), .vout_mv(vout_mv)
  );

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Outputs trail the control state by one registered stage
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic set_standby(input logic s);
    @(posedge mclk);
    standby_state <= s;
    settle(3);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_power_up;
    logic [31:0] d;
    check("pulldown after load", 64'(pulldown_on), 64'hf);
    check("regulating after load", 64'(regulating_on), 64'h0);
    check("code after load", 64'(vout_code), 64'(OTP_CODE));
    for (int i = 0; i < 4; i++) begin
      rd(OFS_VOLT_BASE + 8'(4 * i), d);
      check("volt reg", 64'(d), 64'({24'h0, OTP_CODE[4*i +: 4], OTP_CODE[4*i +: 4]}));
      rd(OFS_CTRL_BASE + 8'(4 * i), d);
      check("ctrl reg", 64'(d), 64'({28'h0, OTP_SEL[i], 3'b000}));
    end
    // Software must not be able to move the mode select
    wr(OFS_CTRL_BASE + 8'h08, 32'h0);
    wr(OFS_CTRL_BASE, 32'h8);
    rd(OFS_CTRL_BASE + 8'h08, d);
    check("otp select kept", 64'(d), 64'h8);
    rd(OFS_CTRL_BASE, d);
    check("otp select not set", 64'(d), 64'h0);
    $display("power up test done");
  endtask

  task automatic t_modes;
    logic [31:0] d;
    wr(OFS_CTRL_BASE, 32'h1);
    wr(OFS_CTRL_BASE + 8'h08, 32'h6);
    wr(OFS_CTRL_BASE + 8'h0c, 32'h2);
    settle(2);
    check("run regulating", 64'(regulating_on), 64'h1);
    check("run switch", 64'(pass_switch_closed), 64'h0);
    check("run pulldown", 64'(pulldown_on), 64'he);
    set_standby(1'b1);
    check("stby regulating", 64'(regulating_on), 64'h8);
    check("stby switch", 64'(pass_switch_closed), 64'h4);
    check("stby pulldown", 64'(pulldown_on), 64'h3);
    rd(OFS_STATUS, d);
    check("status", 64'(d), 64'h0001_1244);
    wr(OFS_CTRL_BASE + 8'h08, 32'h2);
    settle(2);
    check("switch opened", 64'(pass_switch_closed), 64'h0);
    set_standby(1'b0);
    check("back to run", 64'(regulating_on), 64'h1);
    $display("mode test done");
  endtask

  task automatic t_codes;
    wr(OFS_CTRL_BASE + 8'h0c, 32'h3);
    for (int k = 0; k < 16; k++) begin
      wr(OFS_VOLT_BASE + 8'h0c, {24'h0, 4'(15 - k), 4'(k)});
      settle(2);
      check("run code", 64'(vout_code[15:12]), 64'(k));
      check("run mv", 64'(vout_mv[63:48]), 64'(MV_TAB[k]));
      set_standby(1'b1);
      check("stby code", 64'(vout_code[15:12]), 64'(15 - k));
      check("stby mv", 64'(vout_mv[63:48]), 64'(MV_TAB[15-k]));
      set_standby(1'b0);
    end
    $display("code test done");
  endtask

  task automatic t_sequencer;
    logic [31:0] d;
    @(posedge mclk);
    seq_enable_set <= 4'h3;
    @(posedge mclk);
    seq_enable_set <= 4'h0;
    rd(OFS_CTRL_BASE + 8'h04, d);
    check("seq enables", 64'(d), 64'h3);
    rd(OFS_CTRL_BASE, d);
    check("seq enables reg0", 64'(d), 64'h3);
    rd(8'h40, d);
    check("unmapped read", 64'(d), 64'h0);
    $display("sequencer test done");
  endtask

  task automatic t_pins;
    wr(OFS_VOLT_BASE + 8'h04, 32'h72);
    wr(OFS_HWCTL, 32'h1);
    settle(12);
    check("pin off", 64'(pulldown_on[1]), 64'h1);
    @(posedge mclk);
    second_reg_enable_pin <= 1'b1;
    settle(12);
    check("pin on", 64'(regulating_on[1]), 64'h1);
    check("pin run code", 64'(vout_code[7:4]), 64'h2);
    @(posedge mclk);
    voltage_select_pin <= 1'b1;
    settle(12);
    check("pin stby code", 64'(vout_code[7:4]), 64'h7);
    check("pin stby mv", 64'(vout_mv[31:16]), 64'(MV_TAB[7]));
    $display("pin test done");
  endtask

  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    settle(3);
    t_power_up();
    t_modes();
    t_codes();
    t_sequencer();
    t_pins();
    print_verdict();
  end

  // Full run needs under 1500 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    print_verdict();
  end

endmodule

`default_nettype wire
